// ### impw_pkg.sv
// constants for the interleaved multiphase pulse timing core
package impw_pkg;
  localparam int PERIOD_W = 16;
  localparam logic [PERIOD_W-1:0] PERIOD_RST = 16'h0078; // cycles per switching period
  localparam int NUM_PH = 3;
  localparam int CUR_W = 12;
  localparam int PERIOD_DIV = 6; // period granularity
  localparam int OFF_SIXTHS = 2; // forced off time
  localparam int WIN_OPEN_SIXTHS = 1; // sample window opens
  localparam int WIN_LEN_SIXTHS = 1; // sample window length
  localparam int SYNC_STAGES = 3;
endpackage

// ### impw_core.sv
// interleaved multiphase pulse timing core
`timescale 1ns/10ps
`default_nettype none
module impw_core
  import impw_pkg::*;
#(
  parameter int PW = PERIOD_W,
  parameter int CW = CUR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // configuration
  input wire logic [PW-1:0] switchingPeriod,
  input wire logic phase3TiedHigh,
  // per-phase inputs
  input wire logic [NUM_PH-1:0] rampCross,
  input wire logic [NUM_PH*CW-1:0] phaseCurrentSense,
  // pulse outputs
  output logic phase1PulseOut,
  output logic phase2PulseOut,
  output logic phase3PulseOut,
  // sample window and held currents
  output logic [NUM_PH-1:0] sampleWindow,
  output logic [NUM_PH*CW-1:0] heldCurrent,
  output logic twoPhaseMode
);

  // pin strap passes three flops, change counted when last two agree
  logic [SYNC_STAGES-1:0] strapSync_q, strapSync_d;
  logic twoPh_q, twoPh_d;
  always_comb begin
    strapSync_d = {strapSync_q[SYNC_STAGES-2:0], phase3TiedHigh};
    twoPh_d = twoPh_q;
    if (strapSync_q[2] == strapSync_q[1]) begin
      twoPh_d = strapSync_q[2];
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strapSync_q <= '0;
      twoPh_q <= 1'b0;
    end else begin
      strapSync_q <= strapSync_d;
      twoPh_q <= twoPh_d;
    end
  end

  // cycle counter; period latched at each cycle start
  logic [PW-1:0] cnt_q, cnt_d, per_q, per_d;
  logic [PW-1:0] sixth, third, half;
  logic cycEnd;
  always_comb begin
    sixth = PW'(per_q / PERIOD_DIV);
    third = PW'(sixth * OFF_SIXTHS);
    half = PW'(sixth * 3);
    cycEnd = (cnt_q >= per_q - 1'b1);
    cnt_d = cycEnd ? '0 : cnt_q + 1'b1;
    per_d = cycEnd ? switchingPeriod : per_q;
    if (per_d < PW'(PERIOD_DIV)) begin
      per_d = PW'(PERIOD_DIV);
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
      per_q <= PERIOD_RST;
    end else begin
      cnt_q <= cnt_d;
      per_q <= per_d;
    end
  end

  // termination points for each phase
  logic [NUM_PH-1:0] term, active;
  always_comb begin
    term[0] = cycEnd;
    term[1] = twoPh_q ? (cnt_q == half - 1'b1) : (cnt_q == third - sixth - 1'b1 + sixth);
    term[2] = !twoPh_q && (cnt_q == third + third - 1'b1);
    active = {!twoPh_q, 2'b11};
  end

  // per-phase pulse, off timer and sample window
  logic [NUM_PH-1:0] pulse_q, pulse_d, win_q, win_d;
  logic [PW-1:0] off_q [NUM_PH];
  logic [PW-1:0] off_d [NUM_PH];
  logic [CW-1:0] held_q [NUM_PH];
  logic [CW-1:0] held_d [NUM_PH];
  genvar g;
  generate
    for (g = 0; g < NUM_PH; g++) begin : gPh
      always_comb begin
        pulse_d[g] = pulse_q[g];
        off_d[g] = off_q[g];
        held_d[g] = held_q[g];
        if (off_q[g] != '0) begin
          off_d[g] = off_q[g] + 1'b1;
        end
        if (!active[g]) begin
          pulse_d[g] = 1'b0;
          off_d[g] = '0;
        end else if (term[g]) begin
          pulse_d[g] = 1'b0;
          off_d[g] = PW'(1);
        end else if (off_q[g] == '0 && rampCross[g]) begin
          pulse_d[g] = 1'b1;
        end
        if (off_q[g] >= third) begin
          off_d[g] = '0;
        end
        win_d[g] = active[g] && (off_d[g] > sixth) && (off_d[g] <= third);
        if (win_q[g] && !win_d[g] && active[g]) begin
          held_d[g] = phaseCurrentSense[g*CW +: CW];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          pulse_q[g] <= 1'b0;
          win_q[g] <= 1'b0;
          off_q[g] <= '0;
          held_q[g] <= '0;
        end else begin
          pulse_q[g] <= pulse_d[g];
          win_q[g] <= win_d[g];
          off_q[g] <= off_d[g];
          held_q[g] <= held_d[g];
        end
      end
      assign heldCurrent[g*CW +: CW] = held_q[g];
    end
  endgenerate

  // outputs straight from flops
  assign phase1PulseOut = pulse_q[0];
  assign phase2PulseOut = pulse_q[1];
  assign phase3PulseOut = pulse_q[2];
  assign sampleWindow = win_q;
  assign twoPhaseMode = twoPh_q;

  // checks: helper counters first, then assertions and covers on what the core drives
  // the helper counts cycles since each phase's own termination event and saturates at
  // its top value; reset loads the top value so a pulse that rises straight after reset
  // is not taken for one that cut its forced off time short
  logic [PW-1:0] sinceTerm_q [NUM_PH];
  logic [PW-1:0] sinceTerm_d [NUM_PH];
  generate
    for (g = 0; g < NUM_PH; g++) begin : gChk
      // restart on the termination event, otherwise count up and stop at the top
      always_comb begin
        sinceTerm_d[g] = sinceTerm_q[g];
        if (term[g] && active[g]) begin
          sinceTerm_d[g] = '0;
        end else if (sinceTerm_q[g] != '1) begin
          sinceTerm_d[g] = sinceTerm_q[g] + 1'b1;
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sinceTerm_q[g] <= '1;
        end else begin
          sinceTerm_q[g] <= sinceTerm_d[g];
        end
      end

      // a pulse may rise only once a third of a cycle has passed since its termination;
      // a shorter off time would leave the current sample without settled conditions
      a_off_hold: assert property (@(posedge clk) disable iff (rst)
        $rose(pulse_q[g]) |-> $past(sinceTerm_q[g]) >= $past(third) - 1'b1)
        else $error("pulse rose inside its forced off time");

      // every rise needs the ramp crossing one cycle before;
      // an idle phase 3 may never rise at all
      a_rise_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(pulse_q[g]) |-> $past(rampCross[g]) && $past(active[g]))
        else $error("pulse rose without a ramp crossing");

      // once the off time is over a crossing raises the pulse on the next edge,
      // unless a termination in the same cycle takes precedence
      a_rise_gate: assert property (@(posedge clk) disable iff (rst)
        !pulse_q[g] && active[g] && rampCross[g] && !term[g] && sinceTerm_q[g] >= third |=> pulse_q[g])
        else $error("pulse did not rise on a ramp crossing after its off time");

      // a high pulse is only ended by its own termination event,
      // or by the phase being switched off
      a_stay_high: assert property (@(posedge clk) disable iff (rst)
        pulse_q[g] && active[g] && !term[g] |=> pulse_q[g])
        else $error("pulse ended without a termination event");

      // the window is only ever open while the pulse is low;
      // a driver switching during the sample would spoil it
      a_win_in_off: assert property (@(posedge clk) disable iff (rst)
        win_q[g] |-> !pulse_q[g])
        else $error("sample window open while the pulse is high");

      // the window opens a sixth of a cycle after the termination event
      a_win_open: assert property (@(posedge clk) disable iff (rst)
        $rose(win_q[g]) |-> sinceTerm_q[g] == sixth)
        else $error("sample window opened at the wrong cycle");

      // a window that closes on its own does so a third of a cycle after the termination,
      // which leaves it open for one sixth; a mode change may cut it short instead
      a_win_close: assert property (@(posedge clk) disable iff (rst)
        $fell(win_q[g]) && $past(active[g]) |-> sinceTerm_q[g] == $past(third))
        else $error("sample window closed at the wrong cycle");

      // the held value takes the current seen at the close of the window
      a_hold_cap: assert property (@(posedge clk) disable iff (rst)
        $fell(win_q[g]) && $past(active[g]) |-> held_q[g] == $past(phaseCurrentSense[g*CW +: CW]))
        else $error("held current not captured at window close");

      // between captures the held value does not move,
      // so balance and limit logic always sees one settled sample
      a_held_still: assert property (@(posedge clk) disable iff (rst)
        $changed(held_q[g]) |-> $fell(win_q[g]))
        else $error("held current changed outside a window close");
    end
  endgenerate

  // phase 1 goes low on the edge after every cycle end;
  // this is the event that all other offsets count from
  a_p1_term: assert property (@(posedge clk) disable iff (rst)
    cycEnd |=> !pulse_q[0])
    else $error("phase 1 not ended at cycle end");

  // the cycle counter starts again from zero after each cycle end,
  // so successive cycle ends lie exactly one period apart
  a_cnt_wrap: assert property (@(posedge clk) disable iff (rst)
    cycEnd |=> cnt_q == '0)
    else $error("cycle counter did not restart");

  // a legal period on the input is taken at the cycle end;
  // it never changes the length of a cycle already running
  a_period_latch: assert property (@(posedge clk) disable iff (rst)
    cycEnd && switchingPeriod >= PW'(PERIOD_DIV) |=> per_q == $past(switchingPeriod))
    else $error("period not taken at cycle end");

  // the counter never reaches the latched period,
  // and the latched period never drops below six
  a_cnt_range: assert property (@(posedge clk) disable iff (rst)
    cnt_q < per_q && per_q >= PW'(PERIOD_DIV))
    else $error("cycle counter or latched period out of range");

  // in three-phase operation phase 2 ends a third of a cycle into the cycle;
  // the mode is taken from the cycle in which the termination was decoded
  a_p2_three: assert property (@(posedge clk) disable iff (rst)
    $fell(pulse_q[1]) && !$past(twoPh_q) |-> $past(cnt_q) == $past(third) - 1'b1)
    else $error("phase 2 offset wrong in three-phase operation");

  // and phase 3 a further third later; a fall forced by entering
  // two-phase operation is left out by the mode guard
  a_p3_three: assert property (@(posedge clk) disable iff (rst)
    $fell(pulse_q[2]) && !$past(twoPh_q) |-> $past(cnt_q) == $past(third) + $past(third) - 1'b1)
    else $error("phase 3 offset wrong in three-phase operation");

  // with phase 3 strapped high phase 2 ends half a cycle in,
  // which keeps the two remaining phases evenly spread
  a_p2_two: assert property (@(posedge clk) disable iff (rst)
    $fell(pulse_q[1]) && $past(twoPh_q) |-> $past(cnt_q) == $past(half) - 1'b1)
    else $error("phase 2 half offset wrong");

  // the mode only follows the strap once two synchroniser stages agree,
  // so a strap glitch lasting a single cycle cannot toggle the phase count
  a_strap_filter: assert property (@(posedge clk) disable iff (rst)
    $changed(twoPh_q) |-> $past(strapSync_q[2]) == $past(strapSync_q[1]) && twoPh_q == $past(strapSync_q[2]))
    else $error("mode changed without a settled strap");

  // with phase 3 idle neither its pulse nor its window shows;
  // its driver and current channel are simply not fitted then
  a_p3_idle: assert property (@(posedge clk) disable iff (rst)
    twoPh_q |=> !pulse_q[2] && !win_q[2])
    else $error("phase 3 active in two-phase mode");

  // at the default period the phase 1 window lasts at least eight cycles;
  // the exact length is checked per phase by the close check above
  a_win_len: assert property (@(posedge clk) disable iff (rst)
    $rose(win_q[0]) && sixth == PW'(PERIOD_RST / PERIOD_DIV) |-> win_q[0] [*8])
    else $error("window too short");

  // covers for the main scenarios: mode change, phase 3 pulsing,
  // a capture, the half-cycle interleave and the shortest period
  c_two_phase: cover property (@(posedge clk) disable iff (rst) $rose(twoPh_q));
  c_p3_pulse: cover property (@(posedge clk) disable iff (rst) $rose(pulse_q[2]));
  c_capture: cover property (@(posedge clk) disable iff (rst) $fell(win_q[1]));
  c_p2_half: cover property (@(posedge clk) disable iff (rst) $fell(pulse_q[1]) && twoPh_q);
  c_short_period: cover property (@(posedge clk) disable iff (rst) cycEnd && per_q == PW'(PERIOD_DIV));

endmodule
`default_nettype wire

// ### impw_driver_model.sv
// driver-side model that stamps the cycle of each pulse fall
`timescale 1ns/10ps
`default_nettype none
module impw_driver_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pulse lines from the core
  input wire logic [2:0] pulse,
  // cycle stamp of the latest fall per phase
  output logic [2:0][31:0] lastFall
);
  logic [31:0] cyc_q;
  logic [2:0] prev_q;
  // each driver turns its upper switch off on a falling edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cyc_q <= '0;
      prev_q <= '0;
      lastFall <= '0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
      prev_q <= pulse;
      for (int i = 0; i < 3; i++) if (prev_q[i] && !pulse[i]) lastFall[i] <= cyc_q;
    end
  end
endmodule
`default_nettype wire

// ### interleaved_multiphase_pwm_timing_tb.sv
// self-checking bench for the multiphase pulse timing core
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,a) begin checkCount++; if ((a) !== (e)) begin numErrors++; $display("unexpected %s exp %0d got %0d", n, e, a); end end
module interleaved_multiphase_pwm_timing_tb;
  logic clk = 0, rst = 1, tied = 0, p1, p2, p3, two;
  logic [15:0] per = 16'h0078;
  logic [2:0] ramp = 3'h7, win;
  logic [35:0] sense = 36'h3c42b51a6, held;
  logic [2:0][31:0] lastFall;
  int numErrors = 0, checkCount = 0;
  always #2 clk = ~clk;
  impw_core u_dut (.clk(clk), .rst(rst), .switchingPeriod(per), .phase3TiedHigh(tied), .rampCross(ramp),
    .phaseCurrentSense(sense), .phase1PulseOut(p1), .phase2PulseOut(p2), .phase3PulseOut(p3),
    .sampleWindow(win), .heldCurrent(held), .twoPhaseMode(two));
  impw_driver_model u_drv (.clk(clk), .rst(rst), .pulse({p3, p2, p1}), .lastFall(lastFall));
  // wait for the next fall of one phase and return its stamp
  task automatic fall(input int i, output int t);
    int o;
    o = lastFall[i];
    repeat (400) begin
      @(negedge clk);
      if (lastFall[i] != o) break;
    end
    t = lastFall[i];
  endtask
  task automatic endSim;
    $display("errors %0d checks %0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // phase spacing, forced off time, sample window and held current
  task automatic scenInterleave(input int p);
    int t1, t2, t3, t4, first, len;
    first = 0;
    len = 0;
    per = p[15:0];
    fall(0, t1);
    fall(0, t1);
    fall(1, t2);
    fall(2, t3);
    fall(0, t4);
    `CHK("ph2 offset", p / 3, t2 - t1)
    `CHK("ph3 offset", p / 3, t3 - t2)
    `CHK("period", p, t4 - t1)
    // line up on the first low cycle of the next phase 1 pulse, new sample value
    while (p1 !== 1'b1) @(negedge clk);
    while (p1 !== 1'b0) @(negedge clk);
    sense[11:0] = 12'h5c3;
    for (int j = 1; j <= p / 3; j++) begin
      @(negedge clk);
      if (j < p / 3) `CHK("off time", 0, p1)
      if (win[0] && first == 0) first = j;
      len += win[0];
    end
    `CHK("win open", p / 6, first)
    `CHK("win len", p / 6, len)
    repeat (2) @(negedge clk);
    `CHK("held", 12'h5c3, held[11:0])
    `CHK("held2", 12'h2b5, held[23:12])
    `CHK("held3", 12'h3c4, held[35:24])
    sense[11:0] = 12'h0;
    @(negedge clk);
    `CHK("held keep", 12'h5c3, held[11:0])
    sense[11:0] = 12'h1a6;
  endtask
  // low ramp crossing keeps the pulse off, a late crossing raises it
  task automatic scenRamp(input int p);
    int t;
    ramp = 3'h6;
    fall(0, t);
    for (int j = 1; j <= p - 2; j++) begin
      @(negedge clk);
      if (j == p / 2) ramp = 3'h7;
      if (j < p / 2) `CHK("no cross", 0, p1)
      else if (j >= p / 2 + 3) `CHK("stay high", 1, p1)
    end
  endtask
  // strapped phase 3 gives half-cycle interleave on two phases
  task automatic scenTwo(input int p);
    int t1, t2;
    tied = 1;
    repeat (3) fall(0, t1);
    fall(1, t2);
    `CHK("half offset", p / 2, t2 - t1)
    `CHK("two mode", 1, two)
    repeat (p) begin
      @(negedge clk);
      `CHK("ph3 idle", 0, p3)
      `CHK("win3 idle", 0, win[2])
    end
    tied = 0;
    repeat (3) fall(0, t1);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    rst = 0;
    scenInterleave(120);
    scenRamp(120);
    scenTwo(120);
    scenInterleave(60);
    scenInterleave(6);
    endSim;
  end
  initial begin
    #100000;
    numErrors++;
    endSim;
  end
endmodule
`default_nettype wire
